// >>> include/scan_prog_pkg.sv
/*
 * constants, types and the tap next-state function for the scan-port
 * programming front end.
 * assumes a single 20 mhz system clock and a synchronised tck.
 */
package scan_prog_pkg;

	// ----------------------------------------------------------------
	// widths and codes
	// ----------------------------------------------------------------
	localparam int          IR_W         = 4;
	localparam int          UNLOCK_W     = 16;
	localparam int          CMD_W        = 15;
	localparam int          PAGE_BITS    = 1024;
	localparam int          BYTE_W       = 8;
	localparam int          IDX_W        = 7;
	localparam logic [3:0]  INS_RESET    = 4'hc;
	localparam logic [3:0]  INS_UNLOCK   = 4'h4;
	localparam logic [3:0]  INS_COMMAND  = 4'h5;
	localparam logic [3:0]  INS_PAGELOAD = 4'h6;
	localparam logic [3:0]  INS_BYPASS   = 4'hf;
	localparam logic [3:0]  IR_CAPTURE   = 4'h1;
	localparam logic [15:0] UNLOCK_SIG   = 16'ha370;
	localparam logic [15:0] UNLOCK_RST   = 16'h0000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS  = 50;
	localparam int          CLEAR_CLOCKS   = 2;
	localparam int          TIMEOUT_NS     = 3200;
	localparam int          TIMEOUT_CYCLES =
		(TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		TLR   = 4'b0000, RTI   = 4'b0001, SELDR = 4'b0010,
		CAPDR = 4'b0011, SHDR  = 4'b0100, EX1DR = 4'b0101,
		PADR  = 4'b0110, EX2DR = 4'b0111, UPDR  = 4'b1000,
		SELIR = 4'b1001, CAPIR = 4'b1010, SHIR  = 4'b1011,
		EX1IR = 4'b1100, PAIR  = 4'b1101, EX2IR = 4'b1110,
		UPIR  = 4'b1111
	} tap_e;

	function automatic tap_e tap_next(input tap_e s, input logic tms);
		unique case (s)
			TLR:   tap_next = tms ? TLR   : RTI;
			RTI:   tap_next = tms ? SELDR : RTI;
			SELDR: tap_next = tms ? SELIR : CAPDR;
			CAPDR: tap_next = tms ? EX1DR : SHDR;
			SHDR:  tap_next = tms ? EX1DR : SHDR;
			EX1DR: tap_next = tms ? UPDR  : PADR;
			PADR:  tap_next = tms ? EX2DR : PADR;
			EX2DR: tap_next = tms ? UPDR  : SHDR;
			UPDR:  tap_next = tms ? SELDR : RTI;
			SELIR: tap_next = tms ? TLR   : CAPIR;
			CAPIR: tap_next = tms ? EX1IR : SHIR;
			SHIR:  tap_next = tms ? EX1IR : SHIR;
			EX1IR: tap_next = tms ? UPIR  : PAIR;
			PAIR:  tap_next = tms ? EX2IR : PAIR;
			EX2IR: tap_next = tms ? UPIR  : SHIR;
			UPIR:  tap_next = tms ? SELDR : RTI;
		endcase
	endfunction : tap_next

endpackage : scan_prog_pkg

// >>> hdl/pin_sync.sv
/*
 * two-flop synchroniser for a group of pin levels.
 * assumes each bit is an independent level; no bus coherence.
 */
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             mclk_in,
	input  wire logic             resetn_in,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_s;

	sync_s r;
	sync_s next_r;

	always_comb begin
		next_r.meta   = async_in;
		next_r.stable = r.meta;
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			r <= '0;
		else
			r <= next_r;
	end

	assign sync_out = r.stable;

endmodule : pin_sync

// >>> hdl/byte_buffer.sv
/*
 * two-entry buffer with valid/ready on both sides.
 * assumes producer holds nothing: a word is taken when valid and ready.
 */
`timescale 1ns/1ns
module byte_buffer #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             mclk_in,
	input  wire logic             resetn_in,
	// fill side
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	// drain side
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);

	typedef struct packed {
		logic [WIDTH-1:0] head;
		logic [WIDTH-1:0] tail;
		logic [1:0]       count;
	} buf_s;

	buf_s r;
	buf_s next_r;
	logic take;
	logic give;

	always_comb begin
		next_r = r;
		take   = in_valid_in && (r.count != 2'h2);
		give   = out_ready_in && (r.count != 2'h0);
		if (give) begin
			next_r.head = r.tail;
		end
		if (take) begin
			if (r.count == 2'h0 || (r.count == 2'h1 && give))
				next_r.head = in_data_in;
			else
				next_r.tail = in_data_in;
		end
		next_r.count = r.count + 2'(take) - 2'(give);
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			r <= '0;
		else
			r <= next_r;
	end

	assign in_ready_out  = (r.count != 2'h2);
	assign out_valid_out = (r.count != 2'h0);
	assign out_data_out  = r.head;

endmodule : byte_buffer

// >>> hdl/jtag_nvm_programming_port.sv
/*
 * scan-port programming front end: tap controller, instruction register,
 * reset chain, unlock register, command register and page-load chain.
 * assumes tck, tms, tdi and the pins come from outside the clock domain
 * and are slow against mclk_in; the core and page buffer run on mclk_in.
 */
`timescale 1ns/1ns
// Contract
// - programming needs only tck, tms, tdi, tdo; no reset or clock pin.
// - port works only with enable fuse set and disable bit clear.
// - disable bit set plus external reset low clears it after two clocks.
// - reset-clear method not used while pins are dedicated to scan/debug.
// - every shift register shifts least significant bit first.
// - instruction register is four bits, picking the data register.
// - run-test/idle generates internal clocks; also a legal idle point.
// - code 0xc selects a one-bit reset chain; tap is not reset.
// - device stays in reset while reset chain holds one, unlatched.
// - code 0x4 selects the sixteen-bit unlock register.
// - update-dr compares unlock value; programming mode only on match.
// - code 0x5 selects the fifteen-bit command register.
// - capture-dr loads previous command result into command register.
// - shift-dr shifts result out on tdo while new command enters.
// - update-dr presents shifted command to the memory interface.
// - run-test/idle with command selected gives one execute clock.
// - code 0x6 selects a 1024-bit page-load chain, shift-dr only.
// - eight-bit shifter moves each byte to page buffer during shift.
// - unlock only when register equals the fixed signature.
// - unlock register clears to zero on power-on reset.
// - reset chain one acts like external reset pin low.
// - after release, reset holds for the time-out period.
module jtag_nvm_programming_port
	import scan_prog_pkg::*;
#(
	parameter int TIMEOUT = TIMEOUT_CYCLES
) (
	// clock and reset
	input  wire logic               mclk_in,
	input  wire logic               resetn_in,
	// scan port pins
	input  wire logic               tck_in,
	input  wire logic               tms_in,
	input  wire logic               tdi_in,
	output logic                    tdo_out,
	output logic                    tdo_oe_n_out,
	// fuse, reset pin and pin ownership
	input  wire logic               scan_port_enable_fuse_in,
	input  wire logic               ext_resetn_in,
	input  wire logic               pins_dedicated_in,
	// core control/status register bit
	input  wire logic               disable_wr_in,
	input  wire logic               disable_wdata_in,
	output logic                    scan_port_disable_bit_out,
	output logic                    scan_port_active_out,
	// core reset
	output logic                    core_reset_out,
	// memory command interface
	input  wire logic [CMD_W-1:0]   cmd_result_in,
	output logic      [CMD_W-1:0]   cmd_word_out,
	output logic                    cmd_exec_out,
	output logic                    prog_mode_out,
	// page buffer stream
	output logic      [BYTE_W-1:0]  page_data_out,
	output logic      [IDX_W-1:0]   page_index_out,
	output logic                    page_valid_out,
	input  wire logic               page_ready_in
);

	typedef struct packed {
		tap_e                tap;
		logic [IR_W-1:0]     ir;
		logic [IR_W-1:0]     ir_shift;
		logic                bypass;
		logic                reset_chain;
		logic [UNLOCK_W-1:0] unlock_sr;
		logic                prog_mode;
		logic [CMD_W-1:0]    cmd_sr;
		logic [CMD_W-1:0]    cmd_word;
		logic                exec;
		logic [BYTE_W-1:0]   page_sr;
		logic [2:0]          bit_cnt;
		logic [IDX_W-1:0]    byte_idx;
		logic                tck_d;
		logic                rise_pend;
		logic                tdo;
		logic                tdo_drive;
		logic                disable_bit;
		logic [1:0]          clr_cnt;
		logic [15:0]         timeout_cnt;
		logic                core_reset;
	} port_s;

	port_s r;
	port_s next_r;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] pins_s;
	logic       tck_s;
	logic       tms_s;
	logic       tdi_s;
	logic       fuse_s;
	logic       ext_n_s;
	logic       dedicated_s;

	pin_sync #(
		.WIDTH (6)
	) u_sync (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.async_in  ({tck_in, tms_in, tdi_in, scan_port_enable_fuse_in,
		             ext_resetn_in, pins_dedicated_in}),
		.sync_out  (pins_s)
	);

	assign {tck_s, tms_s, tdi_s, fuse_s, ext_n_s, dedicated_s} = pins_s;

	// ----------------------------------------------------------------
	// page byte buffer
	// ----------------------------------------------------------------
	logic                    push;
	logic                    buf_ready;
	logic [BYTE_W+IDX_W-1:0] push_word;

	byte_buffer #(
		.WIDTH (BYTE_W + IDX_W)
	) u_buf (
		.mclk_in       (mclk_in),
		.resetn_in     (resetn_in),
		.in_valid_in   (push),
		.in_data_in    (push_word),
		.in_ready_out  (buf_ready),
		.out_valid_out (page_valid_out),
		.out_data_out  ({page_index_out, page_data_out}),
		.out_ready_in  (page_ready_in)
	);

	// ----------------------------------------------------------------
	// tap and data registers
	// ----------------------------------------------------------------
	logic port_en;
	logic rise;
	logic fall;
	logic step;
	logic push_need;
	logic hold;

	always_comb begin
		next_r    = r;
		port_en   = fuse_s && !r.disable_bit;
		rise      = (tck_s && !r.tck_d) || r.rise_pend;
		fall      = !tck_s && r.tck_d;
		push_need = r.tap == SHDR && r.ir == INS_PAGELOAD &&
		            r.prog_mode && r.bit_cnt == 3'h7;
		// a full buffer delays the tck edge rather than losing a byte
		step      = rise && port_en && !(push_need && !buf_ready);
		push      = step && push_need;
		push_word = {r.byte_idx, tdi_s, r.page_sr[BYTE_W-1:1]};
		next_r.tck_d     = tck_s;
		next_r.rise_pend = rise && port_en && !step;
		next_r.exec      = 1'b0;

		if (!port_en) begin
			next_r.tap       = TLR;
			next_r.ir        = INS_BYPASS;
			next_r.tdo_drive = 1'b0;
		end else if (step) begin
			next_r.tap = tap_next(r.tap, tms_s);
			unique case (r.tap)
				TLR: begin
					next_r.ir = INS_BYPASS;
				end
				CAPIR: begin
					next_r.ir_shift = IR_CAPTURE;
				end
				SHIR: begin
					next_r.ir_shift = {tdi_s, r.ir_shift[IR_W-1:1]};
				end
				UPIR: begin
					next_r.ir = r.ir_shift;
				end
				CAPDR: begin
					unique case (r.ir)
						INS_COMMAND: begin
							next_r.cmd_sr = cmd_result_in;
						end
						INS_PAGELOAD: begin
							next_r.bit_cnt  = 3'h0;
							next_r.byte_idx = '0;
						end
						default: begin
							next_r.bypass = 1'b0;
						end
					endcase
				end
				SHDR: begin
					unique case (r.ir)
						INS_RESET: begin
							next_r.reset_chain = tdi_s;
						end
						INS_UNLOCK: begin
							next_r.unlock_sr =
								{tdi_s, r.unlock_sr[UNLOCK_W-1:1]};
						end
						INS_COMMAND: begin
							next_r.cmd_sr = {tdi_s, r.cmd_sr[CMD_W-1:1]};
						end
						INS_PAGELOAD: begin
							next_r.page_sr =
								{tdi_s, r.page_sr[BYTE_W-1:1]};
							next_r.bit_cnt = r.bit_cnt + 3'h1;
							if (push_need)
								next_r.byte_idx = r.byte_idx + 7'h01;
						end
						default: begin
							next_r.bypass = tdi_s;
						end
					endcase
				end
				UPDR: begin
					if (r.ir == INS_UNLOCK)
						next_r.prog_mode = (r.unlock_sr == UNLOCK_SIG);
					if (r.ir == INS_COMMAND && r.prog_mode)
						next_r.cmd_word = r.cmd_sr;
				end
				default: begin
				end
			endcase
			if (next_r.tap == RTI && r.tap != RTI &&
			    r.ir == INS_COMMAND && next_r.ir == r.ir &&
			    r.prog_mode)
				next_r.exec = 1'b1;
		end else if (fall) begin
			next_r.tdo_drive = (r.tap == SHIR || r.tap == SHDR);
			if (r.tap == SHIR)
				next_r.tdo = r.ir_shift[0];
			else
				unique case (r.ir)
					INS_RESET:    next_r.tdo = r.reset_chain;
					INS_UNLOCK:   next_r.tdo = r.unlock_sr[0];
					INS_COMMAND:  next_r.tdo = r.cmd_sr[0];
					INS_PAGELOAD: next_r.tdo = r.page_sr[0];
					default:      next_r.tdo = r.bypass;
				endcase
		end

		if (r.disable_bit && !ext_n_s && !dedicated_s) begin
			next_r.clr_cnt = r.clr_cnt + 2'h1;
			if (r.clr_cnt == 2'(CLEAR_CLOCKS - 1)) begin
				next_r.disable_bit = 1'b0;
				next_r.clr_cnt     = 2'h0;
			end
		end else begin
			next_r.clr_cnt = 2'h0;
		end
		// a core write in the same cycle wins over the clear
		if (disable_wr_in)
			next_r.disable_bit = disable_wdata_in;

		hold = next_r.reset_chain || !ext_n_s;
		if (hold)
			next_r.timeout_cnt = 16'(TIMEOUT);
		else if (r.timeout_cnt != 16'h0000)
			next_r.timeout_cnt = r.timeout_cnt - 16'h0001;
		next_r.core_reset = hold || (next_r.timeout_cnt != 16'h0000);
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			r             <= '0;
			r.tap         <= TLR;
			r.ir          <= INS_BYPASS;
			r.unlock_sr   <= UNLOCK_RST;
			r.core_reset  <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign tdo_out                   = r.tdo;
	assign tdo_oe_n_out              = !r.tdo_drive;
	assign scan_port_disable_bit_out = r.disable_bit;
	assign scan_port_active_out      = fuse_s && !r.disable_bit;
	assign core_reset_out            = r.core_reset;
	assign cmd_word_out              = r.cmd_word;
	assign cmd_exec_out              = r.exec;
	assign prog_mode_out             = r.prog_mode;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!resetn_in);

	sequence s_unlock_update;
		step && r.tap == UPDR && r.ir == INS_UNLOCK;
	endsequence

	sequence s_clear_wait;
		r.disable_bit && !ext_n_s && !dedicated_s && !disable_wr_in;
	endsequence

	a_port_gate_off: assert property (
		!port_en |=> r.tap == TLR && !r.tdo_drive
	) else $error("tap not held while port disabled");

	a_disable_clear: assert property (
		s_clear_wait ##1 s_clear_wait |=> !r.disable_bit
	) else $error("disable bit not cleared after two clocks");

	a_lsb_first: assert property (
		step && r.tap == SHDR && r.ir == INS_UNLOCK |=>
			r.unlock_sr == {$past(tdi_s), $past(r.unlock_sr[15:1])}
	) else $error("unlock register not shifted lsb first");

	a_ir_capture: assert property (
		step && r.tap == CAPIR |=> r.ir_shift == IR_CAPTURE
	) else $error("instruction capture pattern wrong");

	a_chain_reset: assert property (
		r.reset_chain |=> core_reset_out
	) else $error("core not reset while chain holds one");

	a_unlock_match: assert property (
		s_unlock_update |=> r.prog_mode == ($past(r.unlock_sr) == UNLOCK_SIG)
	) else $error("programming mode does not follow signature");

	a_cmd_capture: assert property (
		step && r.tap == CAPDR && r.ir == INS_COMMAND |=>
			r.cmd_sr == $past(cmd_result_in)
	) else $error("command result not captured");

	a_exec_pulse: assert property (
		cmd_exec_out |-> r.tap == RTI && r.ir == INS_COMMAND ##1 !cmd_exec_out
	) else $error("execute pulse outside run-test/idle or too long");

	a_page_push: assert property (
		push |-> r.tap == SHDR && r.bit_cnt == 3'h7 && buf_ready
	) else $error("page byte pushed at wrong time");

	a_timeout_hold: assert property (
		$fell(r.reset_chain) && ext_n_s |-> core_reset_out [*2]
	) else $error("reset released before time-out");

endmodule : jtag_nvm_programming_port

// >>> verif/scan_programmer.sv
/*
 * model of the external programmer that drives tck, tms and tdi and samples tdo.
 * assumes a 400 ns tck period and that the device is first in the chain.
 */
`timescale 1ns/1ns
module scan_programmer (
	// scan pins
	output logic      tck_out,
	output logic      tms_out,
	output logic      tdi_out,
	input  wire logic tdo_in
);
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
	end

	// one tck period; tdo sampled just before the fall
	task automatic tap_bit(input logic tms, input logic tdi,
			output logic tdo);
		tms_out = tms;
		tdi_out = tdi;
		#200;
		tck_out = 1'b1;
		#200;
		tdo = tdo_in;
		tck_out = 1'b0;
	endtask : tap_bit

	task automatic reset_tap();
		logic d;
		repeat (5) tap_bit(1'b1, 1'b0, d);
		tap_bit(1'b0, 1'b0, d);
	endtask : reset_tap

	task automatic load_ir(input logic [3:0] code);
		logic d;
		#13;
		tap_bit(1'b1, 1'b0, d);
		tap_bit(1'b1, 1'b0, d);
		tap_bit(1'b0, 1'b0, d);
		tap_bit(1'b0, 1'b0, d);
		for (int i = 0; i < 4; i++) begin
			tap_bit(i == 3, code[i], d);
		end
		tap_bit(1'b1, 1'b0, d);
		tap_bit(1'b0, ~tdi_out, d);
	endtask : load_ir

	task automatic scan_dr(input logic [31:0] data, input int n,
			output logic [31:0] out);
		logic d;
		#13;
		out = '0;
		tap_bit(1'b1, 1'b0, d);
		tap_bit(1'b0, 1'b0, d);
		tap_bit(1'b0, 1'b0, d);
		for (int i = 0; i < n; i++) begin
			tap_bit(i == n - 1, data[i], out[i]);
		end
		tap_bit(1'b1, ~tdi_out, d);
		tap_bit(1'b0, ~tdi_out, d);
	endtask : scan_dr

endmodule : scan_programmer

// >>> verif/jtag_nvm_programming_port_tb.sv
/*
 * self-checking bench for the scan-port programming front end.
 * assumes the programmer model and a page sink driven by the bench.
 */
`timescale 1ns/1ns
module jtag_nvm_programming_port_tb
	import scan_prog_pkg::*;
;
	localparam int TMO  = 40;
	localparam int CEIL = 12000;

	logic              mclk_in, resetn_in, tck_in, tms_in, tdi_in;
	logic              tdo_out, tdo_oe_n_out, fuse_in, ext_resetn_in;
	logic              pins_dedicated_in, disable_wr_in, disable_wdata_in;
	logic              disable_bit_out, active_out, core_reset_out;
	logic [CMD_W-1:0]  cmd_result_in, cmd_word_out;
	logic              cmd_exec_out, prog_mode_out, page_valid_out;
	logic [BYTE_W-1:0] page_data_out;
	logic [IDX_W-1:0]  page_index_out;
	logic              page_ready_in, saw_drive, bit_x;
	logic [31:0]       got;
	logic [14:0]       page_q [$];
	int                n_mismatch = 0;
	int                checked = 0;
	int                n_exec = 0;

	jtag_nvm_programming_port #(.TIMEOUT(TMO)) dut (
		.mclk_in                  (mclk_in),
		.resetn_in                (resetn_in),
		.tck_in                   (tck_in),
		.tms_in                   (tms_in),
		.tdi_in                   (tdi_in),
		.tdo_out                  (tdo_out),
		.tdo_oe_n_out             (tdo_oe_n_out),
		.scan_port_enable_fuse_in (fuse_in),
		.ext_resetn_in            (ext_resetn_in),
		.pins_dedicated_in        (pins_dedicated_in),
		.disable_wr_in            (disable_wr_in),
		.disable_wdata_in         (disable_wdata_in),
		.scan_port_disable_bit_out(disable_bit_out),
		.scan_port_active_out     (active_out),
		.core_reset_out           (core_reset_out),
		.cmd_result_in            (cmd_result_in),
		.cmd_word_out             (cmd_word_out),
		.cmd_exec_out             (cmd_exec_out),
		.prog_mode_out            (prog_mode_out),
		.page_data_out            (page_data_out),
		.page_index_out           (page_index_out),
		.page_valid_out           (page_valid_out),
		.page_ready_in            (page_ready_in)
	);

	scan_programmer prog (
		.tck_out(tck_in),
		.tms_out(tms_in),
		.tdi_out(tdi_in),
		// a released tdo reads inverted
		.tdo_in (tdo_oe_n_out ? !tdo_out : tdo_out)
	);

	initial begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end

	// execute pulses, page sink and tdo drive seen at the pins
	always @(posedge mclk_in) begin
		if (cmd_exec_out === 1'b1) n_exec++;
		if (tdo_oe_n_out === 1'b0) saw_drive = 1'b1;
		if (page_valid_out === 1'b1 && page_ready_in === 1'b1)
			page_q.push_back({page_index_out, page_data_out});
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : tick

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic t_after_reset();
		check("core_reset_on", core_reset_out, 1'b1);
		check("prog_mode_off", prog_mode_out, 1'b0);
		check("tdo_idle", tdo_oe_n_out, 1'b1);
		tick(TMO + 10);
		check("core_reset_off", core_reset_out, 1'b0);
		check("active", active_out, 1'b1);
		prog.reset_tap();
	endtask : t_after_reset

	task automatic t_fuse_off();
		tick(1);
		fuse_in = 1'b0;
		saw_drive = 1'b0;
		tick(4);
		check("active_off", active_out, 1'b0);
		prog.load_ir(INS_UNLOCK);
		prog.scan_dr({16'h0000, UNLOCK_SIG}, UNLOCK_W, got);
		tick(4);
		check("locked", prog_mode_out, 1'b0);
		check("tdo_released", saw_drive, 1'b0);
		fuse_in = 1'b1;
		tick(4);
		check("active_on", active_out, 1'b1);
		prog.reset_tap();
	endtask : t_fuse_off

	task automatic t_disable();
		tick(1);
		disable_wr_in = 1'b1;
		disable_wdata_in = 1'b1;
		tick(1);
		disable_wr_in = 1'b0;
		check("disable_set", disable_bit_out, 1'b1);
		check("active_dis", active_out, 1'b0);
		pins_dedicated_in = 1'b1;
		ext_resetn_in = 1'b0;
		tick(10);
		check("dedicated_keep", disable_bit_out, 1'b1);
		check("pin_reset", core_reset_out, 1'b1);
		pins_dedicated_in = 1'b0;
		tick(2);
		check("clear_early", disable_bit_out, 1'b1);
		tick(6);
		check("clear_done", disable_bit_out, 1'b0);
		ext_resetn_in = 1'b1;
		tick(TMO + 10);
		check("pin_release", core_reset_out, 1'b0);
		prog.reset_tap();
	endtask : t_disable

	task automatic t_reset_chain();
		prog.load_ir(INS_RESET);
		prog.scan_dr(32'h0000_0001, 1, got);
		tick(2);
		check("chain_set", core_reset_out, 1'b1);
		prog.scan_dr(32'h0000_0000, 1, got);
		tick(1);
		check("chain_hold", core_reset_out, 1'b1);
		tick(TMO + 10);
		check("chain_free", core_reset_out, 1'b0);
	endtask : t_reset_chain

	task automatic t_bypass();
		prog.load_ir(4'h9);
		prog.scan_dr(32'h0000_0001, 2, got);
		check("bypass", got[1:0], 2'b10);
	endtask : t_bypass

	task automatic t_unlock();
		logic [15:0] sig [3] = '{16'h0ec5, 16'ha371, UNLOCK_SIG};
		prog.load_ir(INS_UNLOCK);
		for (int i = 0; i < 3; i++) begin
			prog.scan_dr({16'h0000, sig[i]}, UNLOCK_W, got);
			tick(4);
			check("prog_mode", prog_mode_out, i == 2);
		end
		check("tdo_driven", saw_drive, 1'b1);
	endtask : t_unlock

	task automatic t_command();
		logic [14:0] cmd [2] = '{15'h2311, 15'h7fff};
		logic [14:0] res [2] = '{15'h5a3c, 15'h0001};
		int          e0;
		prog.load_ir(INS_COMMAND);
		for (int i = 0; i < 2; i++) begin
			tick(1);
			cmd_result_in = res[i];
			e0 = n_exec;
			prog.scan_dr({17'h0_0000, cmd[i]}, CMD_W, got);
			tick(4);
			check("cmd_capture", got[14:0], res[i]);
			check("cmd_word", cmd_word_out, cmd[i]);
			check("cmd_exec", n_exec - e0, 1);
		end
		prog.tap_bit(1'b0, 1'b0, bit_x);
		tick(4);
		check("exec_once", n_exec - e0, 1);
	endtask : t_command

	task automatic t_page();
		tick(1);
		page_ready_in = 1'b0;
		prog.load_ir(INS_PAGELOAD);
		prog.scan_dr(32'h0000_3ca5, 16, got);
		tick(4);
		check("page_stall", page_valid_out, 1'b1);
		check("page_none", page_q.size(), 0);
		page_ready_in = 1'b1;
		tick(4);
		check("page_count", page_q.size(), 2);
		check("page_b0", page_q[0], {7'h00, 8'ha5});
		check("page_b1", page_q[1], {7'h01, 8'h3c});
		check("page_empty", page_valid_out, 1'b0);
		page_q.delete();
		prog.scan_dr(32'h0000_05c3, 12, got);
		tick(4);
		check("part_count", page_q.size(), 1);
		check("part_b0", page_q[0], {7'h00, 8'hc3});
	endtask : t_page

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (CEIL) @(posedge mclk_in);
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		resetn_in = 1'b0;
		fuse_in = 1'b1;
		ext_resetn_in = 1'b1;
		pins_dedicated_in = 1'b0;
		disable_wr_in = 1'b0;
		disable_wdata_in = 1'b0;
		cmd_result_in = 15'h0000;
		page_ready_in = 1'b0;
		saw_drive = 1'b0;
		tick(20);
		resetn_in = 1'b1;
		t_after_reset();
		t_fuse_off();
		t_disable();
		t_reset_chain();
		t_bypass();
		t_unlock();
		t_command();
		t_page();
		report_and_stop();
	end

endmodule : jtag_nvm_programming_port_tb
